/* File: logic/ars_edge_sync.v */
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// two-stage synchroniser with edge detection on the settled level
// ----------------------------------------------------------------------
module ars_edge_sync #(
   parameter RESET_LEVEL = 1'b0
) (
   input  wire clk_i,
   input  wire rst_n_i,
   input  wire async_i,
   output wire level_o,
   output wire rise_o,
   output wire fall_o
);

   reg meta_q;
   reg sync_q;
   reg prev_q;

   // meta_q feeds sync_q only; edges are taken from the settled stages
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta_q <= RESET_LEVEL;
         sync_q <= RESET_LEVEL;
         prev_q <= RESET_LEVEL;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign level_o = sync_q;
   assign rise_o  = sync_q & ~prev_q;
   assign fall_o  = ~sync_q & prev_q;

endmodule // ars_edge_sync

/* File: logic/ars_regs.vh */
`ifndef ARS_REGS_VH
`define ARS_REGS_VH

// ----------------------------------------------------------------------
// serial reset command and frame shape
// ----------------------------------------------------------------------
`define ARS_RESET_CMD        16'h0011
`define ARS_FRAME_WORDS      4'hA
`define ARS_WORD_W           16

// ----------------------------------------------------------------------
// start-up timing in modulator periods, fast-filter sample count and chop length factor
// ----------------------------------------------------------------------
`define ARS_MOD_WAIT_BASE    20'h00100
`define ARS_MOD_WAIT_EXTRA   20'h0002C
`define ARS_FAST_SAMPLES     2'h2
`define ARS_GC_INTERNAL      20'h00003

// ----------------------------------------------------------------------
// counter widths and reset values
// ----------------------------------------------------------------------
`define ARS_MODCNT_W         20
`define ARS_RATIO_W          15
`define ARS_GCDLY_W          17
`define ARS_RATIO_DEFAULT    15'h0400
`define ARS_ZERO20           20'h00000

`endif

/* File: logic/ars_startup_seq.v */
`timescale 1ns/10ps
`include "ars_regs.vh"

module ars_startup_seq #(
   parameter POWER_ON_INTERVAL_NS = 250000,
   parameter RESET_LOW_WIDTH_NS   = 2000,
   parameter CLK_MHZ              = 100,
   parameter MOD_DIV              = 2,
   parameter DATA_READY_LOW_CYC   = 8,
   parameter POR_CYC              = (POWER_ON_INTERVAL_NS * CLK_MHZ + 999) / 1000
) (
   input  wire                      clk_i,
   input  wire                      rst_n_i,
   input  wire                      supply_good_i,
   input  wire                      sync_reset_n_i,
   input  wire                      ext_input_clock_i,
   input  wire [`ARS_WORD_W-1:0]    frame_word_i,
   input  wire                      frame_word_stb_i,
   input  wire                      frame_end_i,
   input  wire [`ARS_RATIO_W-1:0]   oversample_ratio_i,
   input  wire                      gc_enable_i,
   input  wire [`ARS_GCDLY_W-1:0]   gc_delay_i,
   output wire                      data_ready_n_o,
   output wire                      spi_ready_o,
   output wire                      cfg_default_o,
   output wire                      mod_run_o,
   output wire                      mod_tick_o,
   output wire                      fast_filter_o,
   output wire                      filter_reset_o,
   output wire                      chop_invert_o,
   output wire                      result_stb_o
);

   // ----------------------------------------------------------------------
   // derived counts
   // ----------------------------------------------------------------------
   localparam PIN_W_CYC_I = (RESET_LOW_WIDTH_NS * CLK_MHZ) / 1000;
   localparam PIN_W_CYC   = (PIN_W_CYC_I < 1) ? 1 : PIN_W_CYC_I;
   localparam [31:0] POR_CNT    = (POR_CYC < 1) ? 32'd1 : POR_CYC;
   localparam [31:0] PIN_W_32   = PIN_W_CYC;
   localparam [31:0] DIV_32     = MOD_DIV - 1;
   localparam [31:0] DR_LOW_32  = DATA_READY_LOW_CYC;
   // counts are cut to their counter widths on purpose
   localparam [15:0] PIN_W_CNT  = PIN_W_32[15:0];
   localparam [7:0]  DIV_LAST   = DIV_32[7:0];
   localparam [7:0]  DR_LOW_CNT = DR_LOW_32[7:0];
   localparam [`ARS_MODCNT_W-1:0] MOD_WAIT = `ARS_MOD_WAIT_BASE + `ARS_MOD_WAIT_EXTRA;

   // ----------------------------------------------------------------------
   // states
   // ----------------------------------------------------------------------
   localparam [2:0] ST_POR    = 3'h0;
   localparam [2:0] ST_PINRST = 3'h1;
   localparam [2:0] ST_CMDRST = 3'h2;
   localparam [2:0] ST_WAIT   = 3'h3;
   localparam [2:0] ST_CONV   = 3'h4;

   function in_reset;
      input [2:0] st;
      begin
         in_reset = (st == ST_POR) || (st == ST_PINRST) || (st == ST_CMDRST);
      end
   endfunction

   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   wire supply_ok;
   wire pin_n;
   wire clk_rise;

   ars_edge_sync #(.RESET_LEVEL(1'b0)) u_sync_supply (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .async_i (supply_good_i),
      .level_o (supply_ok),
      .rise_o  (),
      .fall_o  ()
   );

   ars_edge_sync #(.RESET_LEVEL(1'b1)) u_sync_pin (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .async_i (sync_reset_n_i),
      .level_o (pin_n),
      .rise_o  (),
      .fall_o  ()
   );

   ars_edge_sync #(.RESET_LEVEL(1'b0)) u_sync_extclk (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .async_i (ext_input_clock_i),
      .level_o (),
      .rise_o  (clk_rise),
      .fall_o  ()
   );

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   reg [2:0]                state_q, state_d;
   reg [31:0]               por_cnt_q;
   reg [15:0]               pin_low_q;
   reg [7:0]                div_cnt_q;
   reg                      tick_q;
   reg [`ARS_MODCNT_W-1:0]  mod_cnt_q;
   reg [1:0]                smp_cnt_q;
   reg [3:0]                word_cnt_q;
   reg                      cmd_hit_q;
   reg                      cmd_reset_q;
   reg [7:0]                dr_cnt_q;
   reg                      dr_n_q;
   reg                      result_q;
   reg                      filt_rst_q;
   reg                      chop_q;
   reg                      fast_q;

   wire ready      = ~in_reset(state_q);
   wire pin_reset  = (pin_low_q > PIN_W_CNT);
   wire div_wrap   = clk_rise && (div_cnt_q == DIV_LAST);
   wire [`ARS_MODCNT_W-1:0] ratio_ext = {5'h00, oversample_ratio_i};
   wire [`ARS_MODCNT_W-1:0] gc_len  = {3'h0, gc_delay_i} + (ratio_ext * `ARS_GC_INTERNAL);
   wire [`ARS_MODCNT_W-1:0] conv_len = gc_enable_i ? gc_len : ratio_ext;
   wire conv_done  = tick_q && (mod_cnt_q == conv_len - 20'h00001);
   // wait state only, or a long conversion would be cut at the wait length
   wire wait_done  = tick_q && (state_q == ST_WAIT) &&
                     (mod_cnt_q == MOD_WAIT - 20'h00001);
   wire cmd_latch  = frame_end_i && ready && cmd_hit_q &&
                     (word_cnt_q >= `ARS_FRAME_WORDS);

   // ----------------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------------
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_POR: begin
            // stays here until the power-on interval has run from supply good
            if (supply_ok && (por_cnt_q >= POR_CNT - 32'd1))
               state_d = ST_WAIT;
         end
         ST_PINRST: begin
            if (pin_n)
               state_d = ST_WAIT;
         end
         ST_CMDRST: begin
            state_d = ST_WAIT;
         end
         ST_WAIT: begin
            if (wait_done)
               state_d = ST_CONV;
         end
         ST_CONV: begin
            state_d = ST_CONV;
         end
         default: begin
            state_d = ST_POR;
         end
      endcase
      // pin reset overrides every state but power-on, command reset only wait and conversion; loss of supply still wins over both
      if (state_q != ST_POR) begin
         if (pin_reset)
            state_d = ST_PINRST;
         else if (cmd_latch)
            state_d = ST_CMDRST;
      end
      if (!supply_ok)
         state_d = ST_POR;
   end

   always @(posedge clk_i) begin
      if (!rst_n_i)
         state_q <= ST_POR;
      else
         state_q <= state_d;
   end

   // ----------------------------------------------------------------------
   // power-on and pin-width counters
   // ----------------------------------------------------------------------
   always @(posedge clk_i) begin
      if (!rst_n_i || !supply_ok || state_q != ST_POR)
         por_cnt_q <= 32'h00000000;
      else
         por_cnt_q <= por_cnt_q + 32'h00000001;
   end

   // saturates so a very long low pulse cannot wrap back under the width
   always @(posedge clk_i) begin
      if (!rst_n_i || pin_n)
         pin_low_q <= 16'h0000;
      else if (pin_low_q != 16'hFFFF)
         pin_low_q <= pin_low_q + 16'h0001;
   end

   // ----------------------------------------------------------------------
   // modulator period from the external clock
   // ----------------------------------------------------------------------
   // divider restarts at each reset so the wait is counted from reset release
   always @(posedge clk_i) begin
      if (!rst_n_i || in_reset(state_q)) begin
         div_cnt_q <= 8'h00;
         tick_q    <= 1'b0;
      end else begin
         tick_q <= div_wrap;
         if (div_wrap)
            div_cnt_q <= 8'h00;
         else if (clk_rise)
            div_cnt_q <= div_cnt_q + 8'h01;
      end
   end

   // ----------------------------------------------------------------------
   // wait and conversion timing
   // ----------------------------------------------------------------------
   always @(posedge clk_i) begin
      if (!rst_n_i || state_q != state_d) begin
         mod_cnt_q <= `ARS_ZERO20;
      end else if (tick_q) begin
         if (wait_done || (state_q == ST_CONV && conv_done))
            mod_cnt_q <= `ARS_ZERO20;
         else
            mod_cnt_q <= mod_cnt_q + 20'h00001;
      end
   end

   always @(posedge clk_i) begin
      if (!rst_n_i || in_reset(state_q)) begin
         smp_cnt_q  <= 2'h0;
         fast_q     <= 1'b1;
         result_q   <= 1'b0;
         filt_rst_q <= 1'b0;
         chop_q     <= 1'b0;
      end else begin
         result_q   <= 1'b0;
         filt_rst_q <= 1'b0;
         if (state_q == ST_CONV && conv_done) begin
            result_q <= 1'b1;
            // both filters run; the fast one only feeds the first samples
            if (smp_cnt_q != `ARS_FAST_SAMPLES)
               smp_cnt_q <= smp_cnt_q + 2'h1;
            fast_q <= (smp_cnt_q < `ARS_FAST_SAMPLES);
            if (gc_enable_i) begin
               chop_q     <= ~chop_q;
               filt_rst_q <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // serial frame watch for the reset command
   // ----------------------------------------------------------------------
   always @(posedge clk_i) begin
      if (!rst_n_i || !ready) begin
         word_cnt_q <= 4'h0;
         cmd_hit_q  <= 1'b0;
      end else if (frame_end_i) begin
         // a frame that ends short leaves no trace
         word_cnt_q <= 4'h0;
         cmd_hit_q  <= 1'b0;
      end else if (frame_word_stb_i) begin
         if (word_cnt_q == 4'h0)
            cmd_hit_q <= (frame_word_i == `ARS_RESET_CMD);
         if (word_cnt_q != 4'hF)
            word_cnt_q <= word_cnt_q + 4'h1;
      end
   end

   always @(posedge clk_i) begin
      if (!rst_n_i)
         cmd_reset_q <= 1'b0;
      else
         cmd_reset_q <= cmd_latch;
   end

   // ----------------------------------------------------------------------
   // data-ready pin
   // ----------------------------------------------------------------------
   // low through any reset, rises on release, then pulses low per result
   always @(posedge clk_i) begin
      if (!rst_n_i || in_reset(state_d)) begin
         dr_n_q   <= 1'b0;
         dr_cnt_q <= 8'h00;
      end else if (result_q) begin
         dr_n_q   <= 1'b0;
         dr_cnt_q <= DR_LOW_CNT;
      end else if (dr_cnt_q > 8'h01) begin
         dr_cnt_q <= dr_cnt_q - 8'h01;
      end else begin
         dr_n_q   <= 1'b1;
         dr_cnt_q <= 8'h00;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign data_ready_n_o = dr_n_q;
   assign spi_ready_o    = (ready & dr_n_q) | (state_q == ST_CONV);
   assign cfg_default_o  = ~ready | cmd_reset_q;
   assign mod_run_o      = (state_q == ST_CONV);
   assign mod_tick_o     = tick_q;
   assign fast_filter_o  = fast_q;
   assign filter_reset_o = filt_rst_q;
   assign chop_invert_o  = chop_q;
   assign result_stb_o   = result_q;

endmodule // ars_startup_seq

/* File: testbench/ars_host_model.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// host side: master clock source and frame sender
// ----------------------------------------------------------------------
module ars_host_model (
   input  wire        clk_i,
   input  wire        run_i,
   input  wire        data_ready_n_i,
   output reg  [15:0] frame_word_o      = 16'hA5A5,
   output reg         frame_word_stb_o  = 1'b0,
   output reg         frame_end_o       = 1'b0,
   output reg         ext_input_clock_o = 1'b0
);
   // master clock stands still while run_i is low
   always #62.5 if (run_i) ext_input_clock_o = ~ext_input_clock_o;
   // hold high: wait for data-ready high first, as a careful host does
   task send_frame(input [15:0] first, input integer n, input hold);
      integer j;
      begin
         while (hold && data_ready_n_i !== 1'b1) @(posedge clk_i);
         for (j = 0; j < n; j = j + 1) begin
            @(posedge clk_i);
            #1;
            frame_word_o = (j == 0) ? first : 16'h5000 + j[15:0];
            frame_word_stb_o = 1'b1;
         end
         @(posedge clk_i);
         #1;
         frame_word_stb_o = 1'b0;
         frame_word_o = ~frame_word_o;
         frame_end_o = 1'b1;
         @(posedge clk_i);
         #1;
         frame_end_o = 1'b0;
      end
   endtask
endmodule // ars_host_model

/* File: testbench/ars_startup_seq_bench.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// start-up, command, pin and chop scenarios
// ----------------------------------------------------------------------
module ars_startup_seq_bench;
   localparam integer RATIO = 4, MODP = 25, GCD = 10;   // MODP: clk cycles per modulator period
   reg         clk_i = 1'b0, rst_n_i = 1'b0, supply_good_i = 1'b0, sync_reset_n_i = 1'b1;
   reg         gc_enable_i = 1'b0, ext_run = 1'b0, fr_seen = 1'b0;
   wire [15:0] word;
   wire        stb, fend, ext_clk, data_ready_n, spi_rdy, cfg_def, run, fast, fres, res, chop;
   integer     err_total = 0, n_checks = 0, cyc, k;
   ars_startup_seq #(.POR_CYC(20), .RESET_LOW_WIDTH_NS(500)) i_ars_startup_seq (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .supply_good_i(supply_good_i),
      .sync_reset_n_i(sync_reset_n_i), .ext_input_clock_i(ext_clk), .frame_word_i(word),
      .frame_word_stb_i(stb), .frame_end_i(fend), .oversample_ratio_i(RATIO[14:0]),
      .gc_enable_i(gc_enable_i), .gc_delay_i(GCD[16:0]), .data_ready_n_o(data_ready_n),
      .spi_ready_o(spi_rdy), .cfg_default_o(cfg_def), .mod_run_o(run), .mod_tick_o(),
      .fast_filter_o(fast), .filter_reset_o(fres), .chop_invert_o(chop), .result_stb_o(res));
   ars_host_model i_ars_host_model (.clk_i(clk_i), .run_i(ext_run),
      .data_ready_n_i(data_ready_n),
      .frame_word_o(word), .frame_word_stb_o(stb), .frame_end_o(fend),
      .ext_input_clock_o(ext_clk));
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) if (fres === 1'b1) fr_seen <= 1'b1;
   task step(input integer n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task check(input [31:0] seen, input [31:0] exp);
      n_checks = n_checks + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("BAD %0t seen %0h want %0h", $time, seen, exp);
      end
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // which: 0 result strobe, 1 modulators running, 2 data-ready high
   task wait_on(input integer which, input integer lim);
      cyc = 0;
      while (cyc < lim && (which == 0 ? res : which == 1 ? run : data_ready_n) !== 1'b1) begin
         step(1);
         cyc = cyc + 1;
      end
   endtask
   task start_seq;
      wait_on(1, 9000);
      check(cyc >= 300 * MODP - 60 && cyc <= 300 * MODP + 60, 1);
      for (k = 0; k < 3; k = k + 1) begin
         wait_on(0, 2 * RATIO * MODP);
         check(res, 1'b1);
         check(fast, k < 2);
         if (k > 0) check(cyc >= RATIO * MODP - 4 && cyc <= RATIO * MODP + 2, 1);
         step(1);
         check(data_ready_n, 1'b0);
      end
   endtask
   task t_por;
      step(40);
      check(data_ready_n, 1'b0);
      check(cfg_def, 1'b1);
      supply_good_i = 1'b1;
      wait_on(2, 100);
      check(cyc >= 20 && cyc <= 26, 1);
      check(spi_rdy, 1'b1);
      // no master clock yet, so the modulators must stay idle
      step(1500);
      check(run, 1'b0);
      ext_run = 1'b1;
      start_seq;
   endtask
   task t_cmd;
      i_ars_host_model.send_frame(16'h0011, 9, 1'b1);
      step(2);
      check(cfg_def, 1'b0);
      i_ars_host_model.send_frame(16'h0022, 10, 1'b1);
      step(2);
      check(cfg_def, 1'b0);
      i_ars_host_model.send_frame(16'h0011, 10, 1'b1);
      check(cfg_def, 1'b1);
      check(data_ready_n, 1'b0);
      step(1);
      check(data_ready_n, 1'b1);
      check(run, 1'b0);
      start_seq;
   endtask
   task t_pin;
      sync_reset_n_i = 1'b0;
      step(30);
      sync_reset_n_i = 1'b1;
      step(8);
      check(cfg_def, 1'b0);
      sync_reset_n_i = 1'b0;
      step(120);
      check(cfg_def, 1'b1);
      step(200);
      check(data_ready_n | run, 1'b0);
      sync_reset_n_i = 1'b1;
      wait_on(2, 20);
      check(cyc >= 1 && cyc <= 8, 1);
      start_seq;
   endtask
   task t_gc;
      gc_enable_i = 1'b1;
      repeat (2) begin
         wait_on(0, 2000);
         check(res, 1'b1);
         step(1);
      end
      wait_on(0, 2000);
      // third chopped result: polarity toggled three times, filter restarted with it
      check(fres, 1'b1);
      check(chop, 1'b1);
      cyc = cyc - (GCD + 3 * RATIO) * MODP;
      check(cyc >= -4 && cyc <= 2, 1);
      check(fr_seen, 1'b1);
   endtask
   initial begin
      repeat (4) @(posedge clk_i);
      #1;
      rst_n_i = 1'b1;
      t_por;
      t_cmd;
      t_pin;
      t_gc;
      close_out;
   end
   // about four times the planned run
   initial begin
      #1000000;
      err_total = err_total + 1;
      close_out;
   end
endmodule // ars_startup_seq_bench
bind ars_startup_seq ars_startup_seq_properties #(.RESET_LOW_WIDTH_NS(RESET_LOW_WIDTH_NS))
   i_ars_startup_seq_properties (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .sync_reset_n_i(sync_reset_n_i),
   .frame_word_i(frame_word_i), .frame_word_stb_i(frame_word_stb_i),
   .frame_end_i(frame_end_i), .oversample_ratio_i(oversample_ratio_i),
   .gc_enable_i(gc_enable_i), .data_ready_n_o(data_ready_n_o), .spi_ready_o(spi_ready_o),
   .cfg_default_o(cfg_default_o), .mod_run_o(mod_run_o), .mod_tick_o(mod_tick_o),
   .fast_filter_o(fast_filter_o), .result_stb_o(result_stb_o));

/* File: testbench/ars_startup_seq_properties.sv */
`timescale 1ns/10ps
`include "ars_regs.vh"
// ----------------------------------------------------------------------
// reset and start-up checks at the sequencer ports
// ----------------------------------------------------------------------
module ars_startup_seq_properties #(
   parameter RESET_LOW_WIDTH_NS = 2000
) (
   input wire        clk_i,
   input wire        rst_n_i,
   input wire        sync_reset_n_i,
   input wire [15:0] frame_word_i,
   input wire        frame_word_stb_i,
   input wire        frame_end_i,
   input wire [14:0] oversample_ratio_i,
   input wire        gc_enable_i,
   input wire        data_ready_n_o,
   input wire        spi_ready_o,
   input wire        cfg_default_o,
   input wire        mod_run_o,
   input wire        mod_tick_o,
   input wire        fast_filter_o,
   input wire        result_stb_o
);
   localparam integer PIN_W_CYC = RESET_LOW_WIDTH_NS * 100 / 1000;
   reg  [15:0] first_q, low_q, gap_q;
   reg  [9:0]  tick_q;
   reg  [3:0]  wcnt_q;
   reg  [1:0]  res_q;
   wire        in_rst = cfg_default_o && !data_ready_n_o;
   wire        acc    = frame_word_stb_i && spi_ready_o;
   // tick, gap and result counts restart in the reset states so each start-up is measured alike
   always @(posedge clk_i) begin
      if (!rst_n_i || frame_end_i) wcnt_q <= 4'h0;
      else if (acc && wcnt_q != 4'hF) wcnt_q <= wcnt_q + 4'h1;
      if (acc && wcnt_q == 4'h0) first_q <= frame_word_i;
      if (!rst_n_i || sync_reset_n_i) low_q <= 16'h0000;
      else if (low_q != 16'hFFFF) low_q <= low_q + 16'h0001;
      if (!rst_n_i || in_rst) begin
         tick_q <= 10'h000;
         gap_q  <= 16'h0000;
         res_q  <= 2'h0;
      end else begin
         tick_q <= tick_q + {9'h000, mod_tick_o && tick_q != 10'h3FF};
         gap_q  <= (result_stb_o ? 16'h0000 : gap_q) + {15'h0000, mod_tick_o};
         res_q  <= res_q + {1'b0, result_stb_o && res_q != 2'h3};
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_good_end; frame_end_i && spi_ready_o && wcnt_q >= 4'hA && first_q == 16'h0011; endsequence
   sequence s_cmd_rst; in_rst ##1 data_ready_n_o; endsequence
   property p_rel; $rose(rst_n_i) |-> in_rst && !spi_ready_o && !mod_run_o; endproperty
   a_rel: assert property (p_rel) else $error("state after reset");
   property p_cmd; s_good_end |=> s_cmd_rst; endproperty
   a_cmd: assert property (p_cmd) else $error("command reset");
   property p_drop; frame_end_i && spi_ready_o && !cfg_default_o
      && (wcnt_q < 4'hA || first_q != 16'h0011) |=> !cfg_default_o; endproperty
   a_drop: assert property (p_drop) else $error("bad frame acted on");
   property p_pin; low_q > PIN_W_CYC + 5 |-> in_rst && !mod_run_o; endproperty
   a_pin: assert property (p_pin) else $error("pin reset");
   property p_wait; $rose(mod_run_o) |-> tick_q >= 10'h12B && tick_q <= 10'h12D; endproperty
   a_wait: assert property (p_wait) else $error("modulator wait");
   property p_fast; result_stb_o |-> fast_filter_o == (res_q < 2'h2); endproperty
   a_fast: assert property (p_fast) else $error("filter choice");
   property p_rate; result_stb_o && res_q != 2'h0 && !gc_enable_i
      |-> gap_q == {1'b0, oversample_ratio_i}; endproperty
   a_rate: assert property (p_rate) else $error("result rate");
   property p_low; result_stb_o |=> (!data_ready_n_o [*8] ##1 data_ready_n_o)
      or (##[0:8] cfg_default_o); endproperty
   a_low: assert property (p_low) else $error("data ready pulse");
endmodule // ars_startup_seq_properties
